// ===== logic/timer_ctrl_pkg.sv
// Package of the timer control slice: register offsets, field layouts,
// action and mode encodings, and reset values.
// Assumes byte-wide registers on a 6-bit byte address.
package timer_ctrl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CONTROL       = 6'h00;
	localparam logic [5:0] ADDR_MODE          = 6'h01;
	localparam logic [5:0] ADDR_CTRLE_CLEAR   = 6'h04;
	localparam logic [5:0] ADDR_CTRLE_SET     = 6'h05;
	localparam logic [5:0] ADDR_BV_CLEAR      = 6'h06;
	localparam logic [5:0] ADDR_BV_SET        = 6'h07;
	localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h09;
	localparam logic [5:0] ADDR_INT_ENABLE    = 6'h0A;
	localparam logic [5:0] ADDR_INT_FLAGS     = 6'h0B;
	localparam logic [5:0] ADDR_DEBUG_CONTROL = 6'h0E;
	localparam logic [5:0] ADDR_TEMP          = 6'h0F;
	localparam logic [5:0] ADDR_COUNT_L       = 6'h20;
	localparam logic [5:0] ADDR_PERIOD_L      = 6'h26;
	localparam logic [5:0] ADDR_COMPARE_BASE  = 6'h28;
	localparam logic [5:0] ADDR_PERIOD_BUFFER_L      = 6'h36;
	localparam logic [5:0] ADDR_CMPBUF_BASE   = 6'h38;
	localparam logic [5:0] PAIR_STRIDE        = 6'h02;
	localparam logic [5:0] HIGH_BYTE          = 6'h01;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ENABLE_BIT      = 0;
	localparam int LOCK_UPDATE_BIT = 1;
	localparam int DIR_BIT         = 0;
	localparam int CMD_LSB         = 2;
	localparam int PERIOD_BV_BIT   = 0;
	localparam int CMP0_BV_BIT     = 1;
	localparam int WRAP_FLAG_BIT   = 0;
	localparam int CMP0_FLAG_BIT   = 4;
	localparam int RUN_DEBUG_BIT   = 0;
	localparam logic [3:0] BV_MASK    = 4'hF;
	localparam logic [7:0] FLAG_MASK  = 8'h71;
	localparam logic [2:0] MODE_MASK  = 3'h7;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [2:0] ACT_B_NONE              = 3'h0;
	localparam logic [2:0] ACT_EVENT_DIRECTION_CONTROL              = 3'h3;
	localparam logic [2:0] ACT_B_RESTART_RISING    = 3'h4;
	localparam logic [2:0] ACT_B_RESTART_EITHER    = 3'h5;
	localparam logic [2:0] ACT_B_RESTART_HIGH      = 3'h6;
	localparam logic [2:0] ACT_A_COUNT_RISING      = 3'h0;
	localparam logic [2:0] ACT_A_COUNT_EITHER      = 3'h1;
	localparam logic [2:0] ACT_A_COUNT_HIGH        = 3'h2;
	localparam logic [1:0] CMD_NONE    = 2'h0;
	localparam logic [1:0] CMD_UPDATE  = 2'h1;
	localparam logic [1:0] CMD_RESTART = 2'h2;
	localparam logic [1:0] CMD_RESET   = 2'h3;

	typedef enum logic [2:0] {
		MODE_NORMAL    = 3'b000,
		MODE_FREQUENCY = 3'b001,
		MODE_RESV2     = 3'b010,
		MODE_SINGLE    = 3'b011,
		MODE_RESV4     = 3'b100,
		MODE_DS_TOP    = 3'b101,
		MODE_DS_BOTH   = 3'b110,
		MODE_DS_BOTTOM = 3'b111
	} waveform_mode_t;

	typedef struct packed {
		logic [2:0] event_action_b;
		logic       event_input_b_enable;
		logic [2:0] event_action_a;
		logic       event_input_a_enable;
	} event_control_t;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO   = 16'h0000;
	localparam logic [15:0] COUNT_ONE    = 16'h0001;

endpackage

// ===== logic/timer_event_irq_buffer_ctrl.sv
// Control slice of a 16-bit timer: buffer-valid flags, event actions,
// compare and wrap interrupt flags, and run-in-debug.
// Assumes a byte register port and event lines synchronous to clk_i.
module timer_event_irq_buffer_ctrl #(
	parameter int PRESCALE_DIV = 1
) (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [5:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        event_a_i,
	input  wire logic        event_b_i,
	input  wire logic        debug_halt_i,
	output logic             irq_o,
	output logic      [15:0] count_o
);

	localparam int CHANNELS = 3;

	initial
	begin
		if (PRESCALE_DIV < 1 || PRESCALE_DIV > 65536)
			$error("PRESCALE_DIV must lie in 1..65536");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic                         enable_reg;
	timer_ctrl_pkg::waveform_mode_t mode_reg;
	logic                         lock_reg;
	logic                         dir_reg;
	logic [3:0]                   bv_reg;
	timer_ctrl_pkg::event_control_t evc_reg;
	logic [7:0]                   ie_reg;
	logic [7:0]                   flags_reg;
	logic                         run_debug_reg;
	logic [7:0]                   temp_reg;
	logic [15:0]                  cnt_reg;
	logic [15:0]                  per_reg;
	logic [15:0]                  period_buffer_reg;
	logic [15:0]                  cmp_reg    [CHANNELS];
	logic [15:0]                  cmpbuf_reg [CHANNELS];
	logic                         a_prev_reg;
	logic                         b_prev_reg;
	logic [15:0]                  presc_reg;
	logic [7:0]                   rdata_reg;
	logic                         irq_reg;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire       wr_control  = wr_i && addr_i == timer_ctrl_pkg::ADDR_CONTROL;
	wire       wr_mode     = wr_i && addr_i == timer_ctrl_pkg::ADDR_MODE;
	wire       wr_e_clr    = wr_i && addr_i == timer_ctrl_pkg::ADDR_CTRLE_CLEAR;
	wire       wr_e_set    = wr_i && addr_i == timer_ctrl_pkg::ADDR_CTRLE_SET;
	wire       wr_bv_clr   = wr_i && addr_i == timer_ctrl_pkg::ADDR_BV_CLEAR;
	wire       wr_bv_set   = wr_i && addr_i == timer_ctrl_pkg::ADDR_BV_SET;
	wire       wr_evc      = wr_i && addr_i == timer_ctrl_pkg::ADDR_EVENT_CONTROL;
	wire       wr_ie       = wr_i && addr_i == timer_ctrl_pkg::ADDR_INT_ENABLE;
	wire       wr_flags    = wr_i && addr_i == timer_ctrl_pkg::ADDR_INT_FLAGS;
	wire       wr_dbg      = wr_i && addr_i == timer_ctrl_pkg::ADDR_DEBUG_CONTROL;
	wire       wr_temp     = wr_i && addr_i == timer_ctrl_pkg::ADDR_TEMP;
	wire       wr_cnt_lo   = wr_i && addr_i == timer_ctrl_pkg::ADDR_COUNT_L;
	wire       wr_cnt_hi   = wr_i && addr_i == (timer_ctrl_pkg::ADDR_COUNT_L
		+ timer_ctrl_pkg::HIGH_BYTE);
	wire       wr_per_lo   = wr_i && addr_i == timer_ctrl_pkg::ADDR_PERIOD_L;
	wire       wr_per_hi   = wr_i && addr_i == (timer_ctrl_pkg::ADDR_PERIOD_L
		+ timer_ctrl_pkg::HIGH_BYTE);
	wire       wr_pbuf_lo  = wr_i && addr_i == timer_ctrl_pkg::ADDR_PERIOD_BUFFER_L;
	wire       wr_pbuf_hi  = wr_i && addr_i == (timer_ctrl_pkg::ADDR_PERIOD_BUFFER_L
		+ timer_ctrl_pkg::HIGH_BYTE);
	wire [1:0] cmd_word    = wdata_i[timer_ctrl_pkg::CMD_LSB +: 2];
	wire       wr_e_any    = wr_e_clr || wr_e_set;

	logic [CHANNELS-1:0] wr_cmp_lo;
	logic [CHANNELS-1:0] wr_cmp_hi;
	logic [CHANNELS-1:0] wr_cbuf_lo;
	logic [CHANNELS-1:0] wr_cbuf_hi;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_chan_dec
			localparam logic [5:0] CMP_LO  = 6'(timer_ctrl_pkg::ADDR_COMPARE_BASE
				+ timer_ctrl_pkg::PAIR_STRIDE * g);
			localparam logic [5:0] CBUF_LO = 6'(timer_ctrl_pkg::ADDR_CMPBUF_BASE
				+ timer_ctrl_pkg::PAIR_STRIDE * g);
			assign wr_cmp_lo[g]  = wr_i && addr_i == CMP_LO;
			assign wr_cmp_hi[g]  = wr_i && addr_i == (CMP_LO + timer_ctrl_pkg::HIGH_BYTE);
			assign wr_cbuf_lo[g] = wr_i && addr_i == CBUF_LO;
			assign wr_cbuf_hi[g] = wr_i && addr_i == (CBUF_LO + timer_ctrl_pkg::HIGH_BYTE);
		end
	endgenerate

	// Low-byte writes park in the shared temp byte; high byte commits both
	wire wr_low_any = wr_temp || wr_cnt_lo || wr_per_lo || wr_pbuf_lo
		|| (|wr_cmp_lo) || (|wr_cbuf_lo);

	// ------------------------------------------------------------
	// Commands
	// ------------------------------------------------------------
	wire cmd_update  = wr_e_any && cmd_word == timer_ctrl_pkg::CMD_UPDATE;
	wire cmd_restart = wr_e_any && cmd_word == timer_ctrl_pkg::CMD_RESTART;
	// Hard reset only while stopped, as running logic would glitch
	wire cmd_reset   = wr_e_any && cmd_word == timer_ctrl_pkg::CMD_RESET && !enable_reg;

	// ------------------------------------------------------------
	// Run gating, prescaler and event sources
	// ------------------------------------------------------------
	wire run        = enable_reg && (!debug_halt_i || run_debug_reg);
	wire presc_tick = run && presc_reg == 16'(PRESCALE_DIV - 1);
	wire ev_a_on    = run && evc_reg.event_input_a_enable;
	wire ev_b_on    = run && evc_reg.event_input_b_enable;
	wire a_rise     = event_a_i && !a_prev_reg;
	wire a_edge     = event_a_i != a_prev_reg;
	wire b_rise     = event_b_i && !b_prev_reg;
	wire b_edge     = event_b_i != b_prev_reg;
	wire [2:0] act_a = evc_reg.event_action_a;
	wire [2:0] act_b = evc_reg.event_action_b;

	wire a_event_direction_control   = ev_a_on && act_a == timer_ctrl_pkg::ACT_EVENT_DIRECTION_CONTROL;
	wire b_event_direction_control   = ev_b_on && act_b == timer_ctrl_pkg::ACT_EVENT_DIRECTION_CONTROL;
	// Reserved B codes fall through to no action
	wire b_restart  = ev_b_on && (
		(act_b == timer_ctrl_pkg::ACT_B_RESTART_RISING && b_rise) ||
		(act_b == timer_ctrl_pkg::ACT_B_RESTART_EITHER && b_edge) ||
		(act_b == timer_ctrl_pkg::ACT_B_RESTART_HIGH && event_b_i));
	wire restart    = b_restart || cmd_restart || cmd_reset;

	logic count_src;
	always_comb
	begin
		count_src = presc_tick;
		if (ev_a_on)
		begin
			case (act_a)
				timer_ctrl_pkg::ACT_A_COUNT_RISING: count_src = a_rise;
				timer_ctrl_pkg::ACT_A_COUNT_EITHER: count_src = a_edge;
				timer_ctrl_pkg::ACT_A_COUNT_HIGH:   count_src = presc_tick && event_a_i;
				timer_ctrl_pkg::ACT_EVENT_DIRECTION_CONTROL:         count_src = presc_tick;
				default:                            count_src = 1'b0;
			endcase
		end
	end

	wire count_tick = run && count_src && !restart;
	// Event level picks the direction; A's up/down outranks B's
	wire down_sel   = a_event_direction_control ? event_a_i
		: b_event_direction_control ? event_b_i : dir_reg;

	// ------------------------------------------------------------
	// Counter sequencing
	// ------------------------------------------------------------
	wire        dual = mode_reg == timer_ctrl_pkg::MODE_DS_TOP
		|| mode_reg == timer_ctrl_pkg::MODE_DS_BOTH
		|| mode_reg == timer_ctrl_pkg::MODE_DS_BOTTOM;
	wire [15:0] top  = mode_reg == timer_ctrl_pkg::MODE_FREQUENCY ? cmp_reg[0] : per_reg;

	logic [15:0] cnt_next;
	logic        dir_next;
	logic        top_evt;
	logic        bot_evt;
	always_comb
	begin
		cnt_next = cnt_reg;
		dir_next = dir_reg;
		top_evt  = 1'b0;
		bot_evt  = 1'b0;
		if (restart)
		begin
			cnt_next = timer_ctrl_pkg::COUNT_ZERO;
			dir_next = 1'b0;
		end
		else if (count_tick)
		begin
			dir_next = down_sel;
			if (!down_sel)
			begin
				if (cnt_reg >= top)
				begin
					top_evt = 1'b1;
					if (dual)
					begin
						cnt_next = cnt_reg - timer_ctrl_pkg::COUNT_ONE;
						dir_next = 1'b1;
					end
					else
						cnt_next = timer_ctrl_pkg::COUNT_ZERO;
				end
				else
					cnt_next = cnt_reg + timer_ctrl_pkg::COUNT_ONE;
			end
			else if (cnt_reg == timer_ctrl_pkg::COUNT_ZERO)
			begin
				bot_evt = 1'b1;
				if (dual)
				begin
					cnt_next = timer_ctrl_pkg::COUNT_ONE;
					dir_next = 1'b0;
				end
				else
					cnt_next = top;
			end
			else
				cnt_next = cnt_reg - timer_ctrl_pkg::COUNT_ONE;
		end
	end

	// Wrap and update conditions per waveform mode
	logic wrap_evt;
	always_comb
	begin
		unique case (mode_reg)
			timer_ctrl_pkg::MODE_DS_TOP:    wrap_evt = top_evt;
			timer_ctrl_pkg::MODE_DS_BOTH:   wrap_evt = top_evt || bot_evt;
			timer_ctrl_pkg::MODE_DS_BOTTOM: wrap_evt = bot_evt;
			default:                        wrap_evt = top_evt || bot_evt;
		endcase
	end
	wire upd_cond  = dual ? bot_evt : (top_evt || bot_evt);
	wire do_update = (upd_cond && !lock_reg) || cmd_update;

	// ------------------------------------------------------------
	// Buffer-valid and interrupt flag next values
	// ------------------------------------------------------------
	logic [3:0] bv_set;
	logic [3:0] bv_clr;
	logic [7:0] flag_set;
	always_comb
	begin
		bv_set = wr_bv_set ? wdata_i[3:0] & timer_ctrl_pkg::BV_MASK : 4'h0;
		bv_set[timer_ctrl_pkg::PERIOD_BV_BIT] = bv_set[timer_ctrl_pkg::PERIOD_BV_BIT]
			|| wr_pbuf_hi;
		flag_set = 8'h00;
		flag_set[timer_ctrl_pkg::WRAP_FLAG_BIT] = wrap_evt;
		for (int n = 0; n < CHANNELS; n++)
		begin
			bv_set[timer_ctrl_pkg::CMP0_BV_BIT + n] =
				bv_set[timer_ctrl_pkg::CMP0_BV_BIT + n] || wr_cbuf_hi[n];
			flag_set[timer_ctrl_pkg::CMP0_FLAG_BIT + n] =
				count_tick && cnt_next == cmp_reg[n];
		end
		bv_clr = (wr_bv_clr ? wdata_i[3:0] : 4'h0)
			| (do_update || cmd_reset ? timer_ctrl_pkg::BV_MASK : 4'h0);
	end

	wire [3:0] bv_next    = (bv_reg & ~bv_clr) | bv_set;
	wire [7:0] flag_clr   = wr_flags ? wdata_i & timer_ctrl_pkg::FLAG_MASK : 8'h00;
	// Set outranks clear so a same-cycle event survives
	wire [7:0] flags_next = (flags_reg & ~flag_clr) | flag_set;
	wire       irq_next   = |(flags_next & ie_reg);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb
	begin
		rd_mux = timer_ctrl_pkg::REG_RESET;
		case (addr_i)
			timer_ctrl_pkg::ADDR_CONTROL:       rd_mux = {7'h00, enable_reg};
			timer_ctrl_pkg::ADDR_MODE:          rd_mux = {5'h00, mode_reg};
			timer_ctrl_pkg::ADDR_CTRLE_CLEAR,
			timer_ctrl_pkg::ADDR_CTRLE_SET:     rd_mux = {6'h00, lock_reg, dir_reg};
			timer_ctrl_pkg::ADDR_BV_CLEAR,
			timer_ctrl_pkg::ADDR_BV_SET:        rd_mux = {4'h0, bv_reg};
			timer_ctrl_pkg::ADDR_EVENT_CONTROL: rd_mux = evc_reg;
			timer_ctrl_pkg::ADDR_INT_ENABLE:    rd_mux = ie_reg;
			timer_ctrl_pkg::ADDR_INT_FLAGS:     rd_mux = flags_reg;
			timer_ctrl_pkg::ADDR_DEBUG_CONTROL: rd_mux = {7'h00, run_debug_reg};
			timer_ctrl_pkg::ADDR_TEMP:          rd_mux = temp_reg;
			timer_ctrl_pkg::ADDR_COUNT_L:       rd_mux = cnt_reg[7:0];
			timer_ctrl_pkg::ADDR_COUNT_L + timer_ctrl_pkg::HIGH_BYTE:
				rd_mux = cnt_reg[15:8];
			timer_ctrl_pkg::ADDR_PERIOD_L:      rd_mux = per_reg[7:0];
			timer_ctrl_pkg::ADDR_PERIOD_L + timer_ctrl_pkg::HIGH_BYTE:
				rd_mux = per_reg[15:8];
			timer_ctrl_pkg::ADDR_PERIOD_BUFFER_L:      rd_mux = period_buffer_reg[7:0];
			timer_ctrl_pkg::ADDR_PERIOD_BUFFER_L + timer_ctrl_pkg::HIGH_BYTE:
				rd_mux = period_buffer_reg[15:8];
			default:                            rd_mux = timer_ctrl_pkg::REG_RESET;
		endcase
		for (int n = 0; n < CHANNELS; n++)
		begin
			if (addr_i == 6'(timer_ctrl_pkg::ADDR_COMPARE_BASE + timer_ctrl_pkg::PAIR_STRIDE * n))
				rd_mux = cmp_reg[n][7:0];
			if (addr_i == 6'(timer_ctrl_pkg::ADDR_COMPARE_BASE + timer_ctrl_pkg::PAIR_STRIDE * n
				+ timer_ctrl_pkg::HIGH_BYTE))
				rd_mux = cmp_reg[n][15:8];
			if (addr_i == 6'(timer_ctrl_pkg::ADDR_CMPBUF_BASE + timer_ctrl_pkg::PAIR_STRIDE * n))
				rd_mux = cmpbuf_reg[n][7:0];
			if (addr_i == 6'(timer_ctrl_pkg::ADDR_CMPBUF_BASE + timer_ctrl_pkg::PAIR_STRIDE * n
				+ timer_ctrl_pkg::HIGH_BYTE))
				rd_mux = cmpbuf_reg[n][15:8];
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			enable_reg    <= 1'b0;
			mode_reg      <= timer_ctrl_pkg::MODE_NORMAL;
			lock_reg      <= 1'b0;
			evc_reg       <= timer_ctrl_pkg::event_control_t'(timer_ctrl_pkg::REG_RESET);
			ie_reg        <= timer_ctrl_pkg::REG_RESET;
			run_debug_reg <= 1'b0;
			temp_reg      <= timer_ctrl_pkg::REG_RESET;
		end
		else
		begin
			if (wr_control)
				enable_reg <= wdata_i[timer_ctrl_pkg::ENABLE_BIT];
			if (wr_mode)
				mode_reg <= timer_ctrl_pkg::waveform_mode_t'(wdata_i[2:0]
					& timer_ctrl_pkg::MODE_MASK);
			if (wr_e_set && wdata_i[timer_ctrl_pkg::LOCK_UPDATE_BIT])
				lock_reg <= 1'b1;
			else if (wr_e_clr && wdata_i[timer_ctrl_pkg::LOCK_UPDATE_BIT])
				lock_reg <= 1'b0;
			if (wr_evc)
				evc_reg <= timer_ctrl_pkg::event_control_t'(wdata_i);
			if (wr_ie)
				ie_reg <= wdata_i & timer_ctrl_pkg::FLAG_MASK;
			if (wr_dbg)
				run_debug_reg <= wdata_i[timer_ctrl_pkg::RUN_DEBUG_BIT];
			if (wr_low_any)
				temp_reg <= wdata_i;
		end
	end

	// ------------------------------------------------------------
	// Counter, buffers and flags
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_reg    <= timer_ctrl_pkg::COUNT_ZERO;
			dir_reg    <= 1'b0;
			per_reg    <= timer_ctrl_pkg::PERIOD_RESET;
			period_buffer_reg <= timer_ctrl_pkg::PERIOD_RESET;
			bv_reg     <= 4'h0;
			flags_reg  <= timer_ctrl_pkg::REG_RESET;
			a_prev_reg <= 1'b0;
			b_prev_reg <= 1'b0;
			presc_reg  <= timer_ctrl_pkg::COUNT_ZERO;
			for (int n = 0; n < CHANNELS; n++)
			begin
				cmp_reg[n]    <= timer_ctrl_pkg::COUNT_ZERO;
				cmpbuf_reg[n] <= timer_ctrl_pkg::COUNT_ZERO;
			end
		end
		else
		begin
			// Edge history only advances while running, so a level change made while halted counts as an edge on resume
			if (run)
			begin
				a_prev_reg <= event_a_i;
				b_prev_reg <= event_b_i;
			end
			presc_reg <= (!run || presc_tick) ? timer_ctrl_pkg::COUNT_ZERO
				: presc_reg + timer_ctrl_pkg::COUNT_ONE;
			cnt_reg <= wr_cnt_hi ? {wdata_i, temp_reg} : cnt_next;
			if (wr_e_set && wdata_i[timer_ctrl_pkg::DIR_BIT])
				dir_reg <= 1'b1;
			else if (wr_e_clr && wdata_i[timer_ctrl_pkg::DIR_BIT])
				dir_reg <= 1'b0;
			else
				dir_reg <= dir_next;
			bv_reg    <= bv_next;
			flags_reg <= flags_next;
			if (wr_pbuf_hi)
				period_buffer_reg <= {wdata_i, temp_reg};
			if (wr_per_hi)
				per_reg <= {wdata_i, temp_reg};
			else if (do_update && bv_reg[timer_ctrl_pkg::PERIOD_BV_BIT])
				per_reg <= period_buffer_reg;
			for (int n = 0; n < CHANNELS; n++)
			begin
				if (wr_cbuf_hi[n])
					cmpbuf_reg[n] <= {wdata_i, temp_reg};
				if (wr_cmp_hi[n])
					cmp_reg[n] <= {wdata_i, temp_reg};
				else if (do_update && bv_reg[timer_ctrl_pkg::CMP0_BV_BIT + n])
					cmp_reg[n] <= cmpbuf_reg[n];
			end
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_reg <= timer_ctrl_pkg::REG_RESET;
			irq_reg   <= 1'b0;
		end
		else
		begin
			rdata_reg <= rd_i ? rd_mux : timer_ctrl_pkg::REG_RESET;
			irq_reg   <= irq_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o   = irq_reg;
	assign count_o = cnt_reg;

endmodule

// ===== verif/timer_ctrl_sva.sv
// Checker for the timer control slice, bound to its top module.
// Assumes normal mode, counting up and PRESCALE_DIV of 1.
module timer_ctrl_sva (
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic [5:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        event_a_i,
	input wire logic        event_b_i,
	input wire logic        debug_halt_i,
	input wire logic        irq_o,
	input wire logic [15:0] count_o
);
	logic       en_reg;
	logic       dbg_reg;
	logic [7:0] ie_reg;
	logic [7:0] ev_reg;
	wire        run_w = en_reg && (!debug_halt_i || dbg_reg) && !wr_i;
	// Shadows rebuilt from bus writes, so no body signal is needed
	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i)
			{en_reg, dbg_reg, ie_reg, ev_reg} <= 18'h00000;
		else if (wr_i)
			case (addr_i)
				6'h00: en_reg <= wdata_i[0];
				6'h0E: dbg_reg <= wdata_i[0];
				6'h0A: ie_reg <= wdata_i & 8'h71;
				6'h09: ev_reg <= wdata_i;
				default: ;
			endcase
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence rd_at(logic [5:0] a);
		rd_i && addr_i == a;
	endsequence
	ie_read_a: assert property (rd_at(6'h0A) |=> rdata_o == ie_reg)
		else $error("enable readback wrong");
	halt_freeze_a: assert property (
		debug_halt_i && !dbg_reg && !wr_i |=> $stable(count_o))
		else $error("count moved in debug halt");
	tick_count_a: assert property (
		run_w && ev_reg[4:0] == 5'h00 |=> count_o == $past(count_o) + 16'h0001)
		else $error("tick count wrong");
	edge_count_a: assert property (
		run_w && ev_reg[4:0] == 5'h01 && $rose(event_a_i)
		|=> count_o == $past(count_o) + 16'h0001)
		else $error("edge count wrong");
	edge_hold_a: assert property (
		run_w && ev_reg[4:0] == 5'h01 && !$rose(event_a_i) |=> $stable(count_o))
		else $error("count moved without edge");
	restart_high_a: assert property (
		run_w && ev_reg[7:4] == 4'hD && event_b_i |=> count_o == 16'h0000)
		else $error("no restart while high");
	irq_cause_a: assert property ($rose(irq_o) |-> ie_reg != 8'h00)
		else $error("request without enable");
	// Request drops at the edge that takes the clearing write
	irq_drop_a: assert property ($fell(irq_o) |-> $past(wr_i))
		else $error("request dropped by hardware");
endmodule

bind timer_event_irq_buffer_ctrl timer_ctrl_sva i_sva (.clk_i(clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.event_a_i(event_a_i), .event_b_i(event_b_i), .debug_halt_i(debug_halt_i),
	.irq_o(irq_o), .count_o(count_o));

// ===== verif/event_source.sv
// Model of the event routing network driving the two event lines.
// Assumes event levels launched just after a rising clk_i edge.
module event_source (
	input  wire logic clk_i,
	output logic      event_a_o,
	output logic      event_b_o
);
	initial {event_a_o, event_b_o} = 2'b00;
	task automatic pulse_a(input int n);
		repeat (n)
		begin
			@(posedge clk_i) event_a_o <= 1'b1;
			@(posedge clk_i) event_a_o <= 1'b0;
		end
	endtask
	task automatic set_b(input logic v);
		@(posedge clk_i) event_b_o <= v;
	endtask
endmodule

// ===== verif/timer_event_irq_buffer_ctrl_tb.sv
// Self-checking bench of the timer control slice with an event source.
// Assumes PRESCALE_DIV of 1, so the counter ticks every clock.
module timer_event_irq_buffer_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i;
	logic        resetn_i;
	logic        wr_i;
	logic        rd_i;
	logic        debug_halt_i;
	logic        irq_o;
	logic        event_a_i;
	logic        event_b_i;
	logic [5:0]  addr_i;
	logic [7:0]  wdata_i;
	logic [7:0]  rdata_o;
	logic [15:0] count_o;
	logic [15:0] snap;
	int          failures = 0;
	int          check_count = 0;
	logic [5:0]  acts_addr [5] = '{6'h07, 6'h09, 6'h0A, 6'h0B, 6'h0E};
	timer_event_irq_buffer_ctrl #(.PRESCALE_DIV(1)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.event_a_i(event_a_i), .event_b_i(event_b_i), .debug_halt_i(debug_halt_i),
		.irq_o(irq_o), .count_o(count_o));
	event_source i_src (.clk_i(clk_i), .event_a_o(event_a_i), .event_b_o(event_b_i));
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 check($sformatf("register %h", a), 16'(rdata_o), 16'(exp));
	endtask
	task automatic end_of_test();
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic buffer_valid();
		wr(6'h36, 8'hFF);
		wr(6'h37, 8'hFF);
		rd(6'h07, 8'h01);
		for (int n = 0; n < 3; n++)
		begin
			wr(6'h38 + 6'(2 * n), 8'h10 + 8'(n));
			wr(6'h39 + 6'(2 * n), 8'h00);
			rd(6'h07, 8'((4 << n) - 1));
		end
		wr(6'h06, 8'h0F);
		wr(6'h07, 8'h0A);
		wr(6'h07, 8'h00);
		rd(6'h07, 8'h0A);
		wr(6'h07, 8'h0F);
		wr(6'h05, 8'h02);
		wr(6'h05, 8'h04);
		rd(6'h07, 8'h00);
		for (int n = 0; n < 3; n++)
			rd(6'h28 + 6'(2 * n), 8'h10 + 8'(n));
		wr(6'h04, 8'h02);
	endtask
	task automatic compare_irq();
		wr(6'h0A, 8'h10);
		wr(6'h00, 8'h01);
		repeat (30) @(posedge clk_i);
		wr(6'h00, 8'h00);
		rd(6'h0B, 8'h70);
		check("irq", 16'(irq_o), 16'h0001);
		wr(6'h0B, 8'h10);
		rd(6'h0B, 8'h60);
		check("irq", 16'(irq_o), 16'h0000);
		wr(6'h0A, 8'h20);
		rd(6'h0B, 8'h60);
		check("irq", 16'(irq_o), 16'h0001);
		wr(6'h0B, 8'h60);
		rd(6'h0B, 8'h00);
		check("irq", 16'(irq_o), 16'h0000);
	endtask
	task automatic debug_run();
		wr(6'h00, 8'h01);
		debug_halt_i <= 1'b1;
		@(posedge clk_i);
		#1 snap = count_o;
		repeat (5) @(posedge clk_i);
		#1 check("count", count_o, snap);
		wr(6'h0E, 8'h01);
		@(posedge clk_i);
		#1 snap = count_o;
		repeat (5) @(posedge clk_i);
		#1 check("count", count_o, snap + 16'h0005);
		debug_halt_i <= 1'b0;
	endtask
	task automatic event_actions();
		logic [7:0] acts [4] = '{8'h01, 8'h03, 8'h05, 8'h0F};
		logic [7:0] bev [4] = '{8'h91, 8'hB1, 8'hD1, 8'hC1};
		int         gain [4] = '{1, 2, 1, 0};
		for (int i = 0; i < 4; i++)
		begin
			wr(6'h09, acts[i]);
			@(posedge clk_i);
			#1 snap = count_o;
			i_src.pulse_a(3);
			@(posedge clk_i);
			#1 check("count", count_o, snap + 16'(3 * gain[i]));
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(6'h09, bev[i]);
			i_src.pulse_a(2);
			@(posedge clk_i);
			#1 snap = count_o;
			i_src.set_b(1'b1);
			@(posedge clk_i);
			#1 check("count", count_o, (i < 3) ? 16'h0000 : snap);
			i_src.set_b(1'b0);
		end
		wr(6'h09, 8'h71);
		@(posedge clk_i);
		#1 snap = count_o;
		i_src.set_b(1'b1);
		i_src.pulse_a(2);
		@(posedge clk_i);
		#1 check("count", count_o, snap - 16'h0002);
		wr(6'h09, 8'h07);
		@(posedge clk_i);
		#1 snap = count_o;
		repeat (4) @(posedge clk_i);
		#1 check("count", count_o, snap + 16'h0004);
	endtask
	initial
	begin
		#200000;
		failures++;
		end_of_test();
	end
	initial
	begin
		{resetn_i, wr_i, rd_i, debug_halt_i} = 4'h0;
		addr_i = 6'h00;
		wdata_i = 8'h00;
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		foreach (acts_addr[i])
			rd(acts_addr[i], 8'h00);
		wr(6'h0A, 8'hFF);
		rd(6'h0A, 8'h71);
		wr(6'h3F, 8'hA5);
		rd(6'h3F, 8'h00);
		buffer_valid();
		compare_irq();
		debug_run();
		event_actions();
		end_of_test();
	end
endmodule
